// file: opmode_pkg.sv
// shared constants, types and register map for the operating mode and reset controller
package opmode_pkg;

   // clock and timing
   localparam int unsigned CLK_KHZ = 20000;
   localparam int unsigned ARM_HOLD_MS = 3000;
   localparam int unsigned ARM_CYCLES = ARM_HOLD_MS * CLK_KHZ;
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned BLINK_CYCLES = BLINK_MS * CLK_KHZ;
   localparam int TMR_W = 26;
   localparam int SYNC_SETTLE = 2; // cycles until the pin synchronisers show the pins

   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_DIAG_INDEX = 12'h008;
   localparam logic [11:0] OFF_DIAG_DATA = 12'h00C;
   localparam logic [11:0] OFF_DIAG_COUNT = 12'h010;

   // control register fields
   localparam int CTRL_STORE_BIT = 0;

   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_SEQ_LSB = 4;
   localparam int STAT_CARD_BIT = 8;
   localparam int STAT_BATT_BIT = 9;
   localparam int STAT_ABORT_BIT = 10;
   localparam int STAT_STORE_BIT = 11;

   // diagnostic event codes
   localparam logic [15:0] EV_CARD_ACCESS = 16'hE100;
   localparam logic [15:0] EV_CARD_FS = 16'hE101;
   localparam logic [15:0] EV_CARD_FAT = 16'hE102;
   localparam logic [15:0] EV_CARD_WRITTEN = 16'hE200;
   localparam logic [15:0] EV_FLASH_WRITTEN = 16'hE300;

   // diagnostic buffer shape
   localparam int DIAG_AW = 4;
   localparam int DIAG_W = 16;
   localparam logic [DIAG_AW:0] DIAG_FULL = 5'h10;

   // synchronised pin indices
   localparam int PIN_RESET_POS = 0;
   localparam int PIN_HALT_POS = 1;
   localparam int PIN_CARD_IN = 2;
   localparam int PIN_BATT_EMPTY = 3;
   localparam int PIN_N = 4;

   typedef enum logic [1:0] {MODE_STOP, MODE_STARTUP, MODE_RUN} mode_t;

   typedef enum logic [3:0] {S_BOOT, S_IDLE, S_HOLD, S_ARMED_WAIT, S_ARMED, S_TIP, S_ERASE, S_LOAD_RESET,
      S_LOAD_FLASH_IMG, S_LOAD_POWERON, S_LOAD_INTFLASH, S_STORE_CARD, S_STORE_FLASH} seq_t;

   typedef enum logic [2:0] {CARD_NONE, CARD_LOAD_RESET, CARD_LOAD_FLASH_IMG, CARD_LOAD_POWERON,
      CARD_LOAD_INTFLASH, CARD_STORE_CARD, CARD_STORE_FLASH} card_op_t;

   typedef enum logic [2:0] {CST_OK, CST_ACCESS, CST_FS, CST_FAT, CST_TOO_BIG} card_stat_t;

   typedef struct packed
   {
      logic done;
      card_stat_t stat;
      logic flash_img_present;
   } card_res_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage : opmode_pkg

// file: diag_event_mem.sv
// diagnostic event buffer storage with registered read data
`timescale 1ns/1ps
module diag_event_mem
   import opmode_pkg::*;
(
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic [DIAG_AW-1:0] wr_addr,
   input wire logic [DIAG_W-1:0] wr_data,
   input wire logic [DIAG_AW-1:0] rd_addr,
   output logic [DIAG_W-1:0] rd_data
);

   logic [DIAG_W-1:0] mem [0:(1<<DIAG_AW)-1];

   // write port
   always_ff @(posedge pclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge pclk)
   begin
      rd_data <= mem[rd_addr];
   end

endmodule : diag_event_mem

// file: operating_mode_reset_controller.sv
// operating mode sequencer, overall reset gesture and card load/store control
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module operating_mode_reset_controller
   import opmode_pkg::*;
#(
   parameter int unsigned ARM_HOLD_CYCLES = ARM_CYCLES,
   parameter int unsigned BLINK_HALF_CYCLES = BLINK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic selector_reset_position,
   input wire logic selector_halt_position,
   input wire logic card_inserted,
   input wire logic battery_empty,
   input wire logic startup_done,
   input wire logic cycle_end,
   input wire logic ram_erase_done,
   input wire card_res_t card_res,
   output logic output_inhibit,
   output logic execution_indicator,
   output logic halt_indicator,
   output logic status_indicator,
   output logic card_activity_indicator,
   output logic startup_routine_call,
   output logic cyclic_main_routine_enable,
   output logic timers_active,
   output logic image_refresh,
   output logic ram_erase_req,
   output card_op_t card_op
);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [PIN_N-1:0] pin_meta_r;
   logic [PIN_N-1:0] pin_s_r;
   logic rst_pos;
   logic halt_pos;
   logic run_pos;
   mode_t mode_r;
   seq_t seq_r;
   logic [TMR_W-1:0] tmr_r;
   logic [TMR_W-1:0] blink_cnt_r;
   logic blink_r;
   logic store_pend_r;
   logic store_take;
   logic load_abort_r;
   logic seq_busy;
   logic diag_wr_r;
   logic [DIAG_W-1:0] diag_wdata_r;
   logic [DIAG_AW-1:0] diag_wptr_r;
   logic [DIAG_AW:0] diag_count_r;
   logic [DIAG_AW-1:0] diag_index_r;
   logic [DIAG_W-1:0] diag_rdata;
   logic rd_wait_r;
   logic apb_access;
   logic apb_wr;
   logic mapped;
   logic card_state;
   logic [DIAG_W-1:0] store_event;

   // two-flop synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++)
      begin : g_sync
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pin_meta_r[gi] <= 1'b0;
               pin_s_r[gi] <= 1'b0;
            end
            else
            begin
               pin_meta_r[gi] <= gi == PIN_RESET_POS ? selector_reset_position :
                  gi == PIN_HALT_POS ? selector_halt_position :
                  gi == PIN_CARD_IN ? card_inserted : battery_empty;
               pin_s_r[gi] <= pin_meta_r[gi];
            end
         end
      end
   endgenerate

   // selector decode: neither position means run
   assign rst_pos = pin_s_r[PIN_RESET_POS];
   assign halt_pos = pin_s_r[PIN_HALT_POS];
   assign run_pos = !rst_pos && !halt_pos;
   assign seq_busy = seq_r != S_IDLE;
   assign card_state = seq_r inside {S_LOAD_RESET, S_LOAD_FLASH_IMG, S_LOAD_POWERON, S_LOAD_INTFLASH,
      S_STORE_CARD, S_STORE_FLASH};

   // free-running blink source
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt_r <= '0;
         blink_r <= 1'b0;
      end
      else if (blink_cnt_r == TMR_W'(BLINK_HALF_CYCLES - 1))
      begin
         blink_cnt_r <= '0;
         blink_r <= !blink_r;
      end
      else
      begin
         blink_cnt_r <= blink_cnt_r + 1'b1;
      end
   end

   // operating mode state machine; leaving to stop clears nothing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= MODE_STOP;
      end
      else
      begin
         case (mode_r)
            MODE_STOP:
               if (run_pos && !seq_busy) mode_r <= MODE_STARTUP;
            MODE_STARTUP:
               if (!run_pos) mode_r <= MODE_STOP;
               else if (startup_done) mode_r <= MODE_RUN;
            MODE_RUN:
               if (!run_pos) mode_r <= MODE_STOP;
            default:
               mode_r <= MODE_STOP;
         endcase
      end
   end

   // startup routine call pulse, one per entry, no time supervision
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         startup_routine_call <= 1'b0;
      end
      else
      begin
         startup_routine_call <= mode_r == MODE_STOP && run_pos && !seq_busy;
      end
   end

   // execution controls and output gating per mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         output_inhibit <= 1'b1;
         execution_indicator <= 1'b0;
         halt_indicator <= 1'b1;
         cyclic_main_routine_enable <= 1'b0;
         timers_active <= 1'b0;
         image_refresh <= 1'b0;
      end
      else
      begin
         output_inhibit <= mode_r != MODE_RUN;
         execution_indicator <= mode_r == MODE_RUN || (mode_r == MODE_STARTUP && blink_r);
         halt_indicator <= mode_r == MODE_STOP;
         cyclic_main_routine_enable <= mode_r == MODE_RUN;
         timers_active <= mode_r == MODE_RUN;
         image_refresh <= mode_r == MODE_RUN && cycle_end;
      end
   end

   // indicators owned by the reset gesture and card sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_indicator <= 1'b0;
         card_activity_indicator <= 1'b0;
      end
      else
      begin
         if (seq_r == S_HOLD || seq_r == S_ERASE)
            status_indicator <= blink_r;
         else
            status_indicator <= mode_r == MODE_STOP;
         card_activity_indicator <= card_state && blink_r;
      end
   end

   // store command is taken only from idle with a card present
   assign store_take = seq_r == S_IDLE && mode_r != MODE_STARTUP && store_pend_r && pin_s_r[PIN_CARD_IN]
      && !(mode_r == MODE_STOP && rst_pos); // a gesture start would otherwise swallow the command

   // reset gesture and card load/store sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_r <= S_BOOT;
         tmr_r <= '0;
         load_abort_r <= 1'b0;
      end
      else
      begin
         tmr_r <= tmr_r + 1'b1;
         case (seq_r)
            S_BOOT:
               if (tmr_r != TMR_W'(SYNC_SETTLE)) seq_r <= S_BOOT; // synced pins still show reset values
               else if (pin_s_r[PIN_CARD_IN]) seq_r <= S_LOAD_POWERON;
               else if (pin_s_r[PIN_BATT_EMPTY]) seq_r <= S_LOAD_INTFLASH;
               else seq_r <= S_IDLE;
            S_IDLE:
            begin
               tmr_r <= '0;
               if (mode_r == MODE_STOP && rst_pos) seq_r <= S_HOLD;
               else if (store_take) seq_r <= S_STORE_CARD;
            end
            S_HOLD:
               if (!rst_pos) seq_r <= S_IDLE;
               else if (tmr_r == TMR_W'(ARM_HOLD_CYCLES - 1)) seq_r <= S_ARMED_WAIT;
            S_ARMED_WAIT:
               if (halt_pos) seq_r <= S_ARMED;
               else if (run_pos) seq_r <= S_IDLE;
            S_ARMED:
            begin
               tmr_r <= '0;
               if (rst_pos) seq_r <= S_TIP;
               else if (run_pos) seq_r <= S_IDLE;
            end
            S_TIP:
               if (halt_pos) seq_r <= S_ERASE;
               else if (run_pos || tmr_r == TMR_W'(ARM_HOLD_CYCLES - 1)) seq_r <= S_IDLE;
            S_ERASE:
               if (ram_erase_done)
               begin
                  load_abort_r <= 1'b0;
                  seq_r <= pin_s_r[PIN_CARD_IN] ? S_LOAD_RESET : S_IDLE;
               end
            S_LOAD_RESET:
               if (card_res.done)
               begin
                  load_abort_r <= card_res.stat == CST_TOO_BIG;
                  if (card_res.stat == CST_OK && card_res.flash_img_present)
                     seq_r <= S_LOAD_FLASH_IMG;
                  else
                     seq_r <= S_IDLE;
               end
            S_LOAD_POWERON, S_LOAD_INTFLASH, S_LOAD_FLASH_IMG:
               if (card_res.done)
               begin
                  load_abort_r <= card_res.stat == CST_TOO_BIG;
                  seq_r <= S_IDLE;
               end
            S_STORE_CARD:
               if (card_res.done) seq_r <= S_STORE_FLASH;
            S_STORE_FLASH:
               if (card_res.done) seq_r <= S_IDLE;
            default:
               seq_r <= S_IDLE;
         endcase
      end
   end

   // requests to the ram eraser and the card/flash engine; the card itself is never erased
   always_comb
   begin
      ram_erase_req = seq_r == S_ERASE;
      case (seq_r)
         S_LOAD_RESET: card_op = CARD_LOAD_RESET;
         S_LOAD_FLASH_IMG: card_op = CARD_LOAD_FLASH_IMG;
         S_LOAD_POWERON: card_op = CARD_LOAD_POWERON;
         S_LOAD_INTFLASH: card_op = CARD_LOAD_INTFLASH;
         S_STORE_CARD: card_op = CARD_STORE_CARD;
         S_STORE_FLASH: card_op = CARD_STORE_FLASH;
         default: card_op = CARD_NONE;
      endcase
   end

   // event code for a finished write
   always_comb
   begin
      case (card_res.stat)
         CST_ACCESS: store_event = EV_CARD_ACCESS;
         CST_FS: store_event = EV_CARD_FS;
         CST_FAT: store_event = EV_CARD_FAT;
         default: store_event = seq_r == S_STORE_FLASH ? EV_FLASH_WRITTEN : EV_CARD_WRITTEN;
      endcase
   end

   // diagnostic logging after each write step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         diag_wr_r <= 1'b0;
         diag_wdata_r <= '0;
      end
      else
      begin
         diag_wr_r <= card_res.done && (seq_r == S_STORE_CARD || seq_r == S_STORE_FLASH);
         diag_wdata_r <= store_event;
      end
   end

   // buffer write pointer and saturating entry count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         diag_wptr_r <= '0;
         diag_count_r <= '0;
      end
      else if (diag_wr_r)
      begin
         diag_wptr_r <= diag_wptr_r + 1'b1;
         if (diag_count_r != DIAG_FULL) diag_count_r <= diag_count_r + 1'b1;
      end
   end

   diag_event_mem u_diag_mem
   (
      .pclk(pclk),
      .wr_en(diag_wr_r),
      .wr_addr(diag_wptr_r),
      .wr_data(diag_wdata_r),
      .rd_addr(diag_index_r),
      .rd_data(diag_rdata)
   );

   // apb decode
   assign apb_access = apb_req.psel && apb_req.penable;
   assign apb_wr = apb_access && apb_req.pwrite && pready;
   assign mapped = apb_req.paddr inside {OFF_CTRL, OFF_STATUS, OFF_DIAG_INDEX, OFF_DIAG_DATA, OFF_DIAG_COUNT};
   assign pready = !(apb_access && !apb_req.pwrite && apb_req.paddr == OFF_DIAG_DATA && !rd_wait_r);
   assign pslverr = apb_access && pready && !mapped;

   // one wait state on buffer data reads
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_wait_r <= 1'b0;
      else
         rd_wait_r <= apb_access && !pready;
   end

   // store command latch; a new request wins over the take
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         store_pend_r <= 1'b0;
      else
         store_pend_r <= (apb_wr && apb_req.paddr == OFF_CTRL && apb_req.pwdata[CTRL_STORE_BIT])
            || (store_pend_r && !store_take);
   end

   // buffer read index
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         diag_index_r <= '0;
      else if (apb_wr && apb_req.paddr == OFF_DIAG_INDEX)
         diag_index_r <= apb_req.pwdata[DIAG_AW-1:0];
   end

   // read data mux
   always_comb
   begin
      prdata = '0;
      case (apb_req.paddr)
         OFF_CTRL: prdata[CTRL_STORE_BIT] = store_pend_r;
         OFF_STATUS:
         begin
            prdata[STAT_MODE_LSB +: 2] = mode_r;
            prdata[STAT_SEQ_LSB +: 4] = seq_r;
            prdata[STAT_CARD_BIT] = pin_s_r[PIN_CARD_IN];
            prdata[STAT_BATT_BIT] = pin_s_r[PIN_BATT_EMPTY];
            prdata[STAT_ABORT_BIT] = load_abort_r;
            prdata[STAT_STORE_BIT] = seq_r == S_STORE_CARD || seq_r == S_STORE_FLASH;
         end
         OFF_DIAG_INDEX: prdata[DIAG_AW-1:0] = diag_index_r;
         OFF_DIAG_DATA: prdata[DIAG_W-1:0] = diag_rdata;
         OFF_DIAG_COUNT: prdata[DIAG_AW:0] = diag_count_r;
         default: prdata = '0;
      endcase
   end

   // checks
   stop_outputs_a: assert property (
      mode_r == MODE_STOP |=> output_inhibit && halt_indicator && !execution_indicator && !timers_active)
      else $error("stop mode outputs wrong");
   startup_call_a: assert property (
      startup_routine_call |-> mode_r == MODE_STARTUP ##1 !startup_routine_call)
      else $error("startup call not single");
   startup_gate_a: assert property (
      mode_r == MODE_STARTUP |=> output_inhibit && !halt_indicator && execution_indicator == $past(blink_r))
      else $error("startup outputs wrong");
   startup_done_a: assert property (
      mode_r == MODE_STARTUP && startup_done && run_pos |=> mode_r == MODE_RUN)
      else $error("startup did not reach run");
   run_refresh_a: assert property (
      mode_r == MODE_RUN && cycle_end |=> image_refresh && cyclic_main_routine_enable)
      else $error("run refresh missing");
   run_outputs_a: assert property (
      mode_r == MODE_RUN |=> !output_inhibit && execution_indicator && !halt_indicator)
      else $error("run outputs wrong");
   arm_steady_a: assert property (
      seq_r == S_HOLD && rst_pos && tmr_r == TMR_W'(ARM_HOLD_CYCLES - 1) |=> seq_r == S_ARMED_WAIT ##1 status_indicator)
      else $error("arming not shown steady");
   tip_erase_a: assert property (
      seq_r == S_TIP && halt_pos |=> ram_erase_req ##1 (status_indicator == $past(blink_r)))
      else $error("erase not started");
   abandon_a: assert property (
      seq_r == S_HOLD && !rst_pos |=> seq_r == S_IDLE && !ram_erase_req)
      else $error("broken gesture not abandoned");
   too_big_a: assert property (
      seq_r == S_LOAD_RESET && card_res.done && card_res.stat == CST_TOO_BIG |=> seq_r == S_IDLE && load_abort_r)
      else $error("oversized load not aborted");
   flash_log_a: assert property (
      seq_r == S_STORE_FLASH && card_res.done && card_res.stat == CST_OK |=> diag_wr_r && diag_wdata_r == EV_FLASH_WRITTEN)
      else $error("flash write event missing");
   store_blink_a: assert property (
      seq_r == S_STORE_CARD |=> card_activity_indicator == $past(blink_r))
      else $error("card indicator not blinking");

endmodule : operating_mode_reset_controller

// file: card_partner.sv
// far-side model: memory card engine and ram eraser with settable latency
`timescale 1ns/1ps
module card_partner
   import opmode_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire card_op_t card_op,
   input wire logic ram_erase_req,
   input wire logic [7:0] lat,
   input wire card_stat_t stat,
   input wire logic flash_img,
   output card_res_t card_res,
   output logic ram_erase_done
);
   logic [7:0] cnt;
   logic [7:0] ecnt;
   logic done_r;
   // one done pulse per card request after lat cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 8'h00;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= card_op != CARD_NONE && !done_r && cnt >= lat;
         cnt <= (card_op != CARD_NONE && !done_r && cnt < lat) ? cnt + 8'h01 : 8'h00;
      end
   end
   // released result lines show junk, never the last answer
   assign card_res = done_r ? {1'b1, stat, flash_img} : {1'b0, CST_TOO_BIG, ~flash_img};
   // ram erase finishes lat cycles after the request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ecnt <= 8'h00;
         ram_erase_done <= 1'b0;
      end
      else
      begin
         ram_erase_done <= ram_erase_req && !ram_erase_done && ecnt >= lat;
         ecnt <= (ram_erase_req && !ram_erase_done && ecnt < lat) ? ecnt + 8'h01 : 8'h00;
      end
   end
endmodule : card_partner

// file: operating_mode_reset_controller_tb_top.sv
// testbench: boot loads, mode sequence, store events, reset gesture, apb access
`timescale 1ns/1ps
module operating_mode_reset_controller_tb_top;
   import opmode_pkg::*;
   logic pclk, presetn, sel_rst, sel_halt, card_in, batt, su_done, cyc_end, flash_img, pready, pslverr, err;
   logic oinh, exec_ind, halt_ind, stat_ind, card_ind, su_call, main_en, tmr_act, refresh, erase_req, erase_done;
   logic [31:0] prdata, rd;
   logic [7:0] lat;
   logic [2:0] lamps;
   card_stat_t stat;
   apb_req_t apb_req;
   card_res_t card_res;
   card_op_t card_op;
   int miscompares, n_checks, i;
   card_stat_t stats [4] = '{CST_OK, CST_ACCESS, CST_FS, CST_FAT};
   logic [15:0] evs [4] = '{EV_CARD_WRITTEN, EV_CARD_ACCESS, EV_CARD_FS, EV_CARD_FAT};
   assign lamps = {exec_ind, stat_ind, card_ind};

   operating_mode_reset_controller #(.ARM_HOLD_CYCLES(20), .BLINK_HALF_CYCLES(4)) dut (.pclk(pclk),
      .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .selector_reset_position(sel_rst), .selector_halt_position(sel_halt), .card_inserted(card_in),
      .battery_empty(batt), .startup_done(su_done), .cycle_end(cyc_end), .ram_erase_done(erase_done),
      .card_res(card_res), .output_inhibit(oinh), .execution_indicator(exec_ind), .halt_indicator(halt_ind),
      .status_indicator(stat_ind), .card_activity_indicator(card_ind), .startup_routine_call(su_call),
      .cyclic_main_routine_enable(main_en), .timers_active(tmr_act), .image_refresh(refresh),
      .ram_erase_req(erase_req), .card_op(card_op));
   card_partner card (.pclk(pclk), .presetn(presetn), .card_op(card_op), .ram_erase_req(erase_req),
      .lat(lat), .stat(stat), .flash_img(flash_img), .card_res(card_res), .ram_erase_done(erase_done));

   // clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task automatic pos(input logic r, input logic h);
      @(posedge pclk);
      sel_rst <= r;
      sel_halt <= h;
   endtask : pos

   task automatic wait_op(input card_op_t o);
      for (i = 0; i < 100 && card_op !== o; i++)
         @(posedge pclk);
   endtask : wait_op

   task automatic wait_idle;
      for (i = 0; i < 100; i++)
      begin
         apb(1'b0, OFF_STATUS, 32'h0);
         if (rd[7:4] == 4'h1)
            break;
      end
      chk(rd[7:4], 4'h1);
   endtask : wait_idle

   task automatic blinks(input int b);
      logic a;
      cyc(1);
      a = lamps[b];
      cyc(4);
      chk(a ^ lamps[b], 1'b1);
   endtask : blinks

   task automatic gesture(input int tip);
      pos(1'b1, 1'b0);
      cyc(8);
      blinks(1);
      cyc(20);
      chk(stat_ind, 1'b1);
      pos(1'b0, 1'b1);
      cyc(4);
      pos(1'b1, 1'b0);
      cyc(tip);
      pos(1'b0, 1'b1);
   endtask : gesture

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // main sequence
   initial
   begin
      apb_req = '0;
      {presetn, sel_rst, su_done, cyc_end, batt} = 5'h00;
      {sel_halt, card_in, flash_img} = 3'h7;
      lat = 8'h14;
      stat = CST_OK;
      cyc(6);
      presetn <= 1'b1;
      wait_op(CARD_LOAD_POWERON);
      chk(card_op, CARD_LOAD_POWERON);
      blinks(0);
      wait_idle;
      chk({rd[1:0], oinh, exec_ind, halt_ind, stat_ind}, 6'h0B);
      apb(1'b0, 12'h020, 32'h0);
      chk(err, 1'b1);
      pos(1'b0, 1'b0);
      for (i = 0; i < 10 && su_call !== 1'b1; i++)
         @(posedge pclk);
      chk(su_call, 1'b1);
      cyc(2);
      chk({su_call, oinh, halt_ind}, 3'b010);
      blinks(2);
      su_done <= 1'b1;
      @(posedge pclk);
      su_done <= 1'b0;
      cyc(3);
      chk({oinh, exec_ind, halt_ind, main_en, tmr_act}, 5'b01011);
      cyc_end <= 1'b1;
      @(posedge pclk);
      cyc_end <= 1'b0;
      @(posedge pclk);
      chk(refresh, 1'b1);
      pos(1'b0, 1'b1);
      cyc(5);
      chk({oinh, exec_ind, halt_ind, main_en}, 4'b1010);
      for (int k = 0; k < 4; k++)
      begin
         stat <= stats[k];
         apb(1'b1, OFF_CTRL, 32'h1);
         wait_op(CARD_STORE_CARD);
         chk(card_op, CARD_STORE_CARD);
         blinks(0);
         wait_op(CARD_STORE_FLASH);
         chk(card_op, CARD_STORE_FLASH);
         wait_idle;
         apb(1'b1, OFF_DIAG_INDEX, 2 * k);
         apb(1'b0, OFF_DIAG_DATA, 32'h0);
         chk(rd, {16'h0, evs[k]});
      end
      apb(1'b0, OFF_DIAG_COUNT, 32'h0);
      chk(rd, 32'h8);
      stat <= CST_OK;
      gesture(3);
      for (i = 0; i < 10 && erase_req !== 1'b1; i++)
         @(posedge pclk);
      chk(erase_req, 1'b1);
      blinks(1);
      wait_op(CARD_LOAD_RESET);
      chk(card_op, CARD_LOAD_RESET);
      wait_op(CARD_LOAD_FLASH_IMG);
      chk(card_op, CARD_LOAD_FLASH_IMG);
      wait_idle;
      chk({rd[1:0], stat_ind}, 3'b001);
      stat <= CST_TOO_BIG;
      gesture(3);
      wait_op(CARD_LOAD_RESET);
      wait_idle;
      chk(rd[10], 1'b1);
      pos(1'b1, 1'b0);
      cyc(8);
      pos(1'b0, 1'b1);
      cyc(8);
      chk(erase_req, 1'b0);
      gesture(30);
      cyc(8);
      chk(erase_req, 1'b0);
      presetn <= 1'b0;
      card_in <= 1'b0;
      batt <= 1'b1;
      cyc(6);
      presetn <= 1'b1;
      wait_op(CARD_LOAD_INTFLASH);
      chk(card_op, CARD_LOAD_INTFLASH);
      end_sim;
   end

   // watchdog against a hang
   initial
   begin
      cyc(20000);
      miscompares++;
      end_sim;
   end
endmodule : operating_mode_reset_controller_tb_top
